// *** dv/pmx_mac_model.sv ***
// mac side transmit model for the mii transmit pins
`timescale 1ns/100ps
`default_nettype none
module pmx_mac_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tx_clk_i,
    input wire logic dirty_idle_i,
    output logic tx_en_o = 1'b0,
    output logic [3:0] txd_o = 4'h0
);
    logic [3:0] q[$];
    logic clk_q;
    task send(input logic [3:0] n);
        q.push_back(n);
    endtask
    // launch right after each transmit clock rise
    always @(posedge clk_i) begin
        clk_q <= tx_clk_i;
        if (rst_i) begin
            tx_en_o <= 1'b0;
            txd_o <= 4'h0;
        end else if (tx_clk_i && !clk_q) begin
            tx_en_o <= q.size() > 0;
            txd_o <= q.size() > 0 ? q.pop_front() : (dirty_idle_i ? 4'ha : 4'h0);
        end
    end
endmodule // pmx_mac_model
`default_nettype wire

// *** dv/pmx_mii_port_monitor.sv ***
// concurrent checks at the ports of the mii port block
`timescale 1ns/100ps
`default_nettype none
module pmx_mii_port_monitor #(
    parameter longint DPD_CYC = 100
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic mii_tx_clk_o,
    input wire logic mii_tx_en_i,
    input wire logic mii_rx_clk_o,
    input wire logic mii_rx_dv_o,
    input wire logic [3:0] mii_rxd_o,
    input wire logic mii_rx_er_o,
    input wire logic mii_crs_o,
    input wire logic mii_col_o,
    input wire pmx_pkg::pmx_line_rx_t line_rx_i,
    input wire logic line_tx_en_o,
    input wire logic [3:0] line_txd_o,
    input wire logic pair_a_is_tx_o,
    input wire logic pair_b_is_tx_o,
    input wire logic deep_power_down_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    longint quiet_r;
    logic [2:0] up_r;
    always_ff @(posedge clk_i) begin
        if (rst_i || mii_tx_en_i || line_rx_i.link) quiet_r <= 0;
        else quiet_r <= quiet_r + 1;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) up_r <= 3'h0;
        else if (up_r != 3'h7) up_r <= up_r + 3'h1;
    end
    sequence s_wb_req;
        wb_cyc_i && $rose(wb_stb_i);
    endsequence
    sequence s_ack_once;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_wb_answer: assert property (s_wb_req |=> s_ack_once)
        else $error("bus acknowledge not one cycle after request");
    a_txclk_half: assert property ($rose(mii_tx_clk_o) |-> mii_tx_clk_o [*5])
        else $error("transmit clock high phase too short");
    a_line_idle: assert property (!line_tx_en_o |-> line_txd_o == 4'h0)
        else $error("line nibble not zero while transmit idle");
    a_rxd_idle: assert property (!mii_rx_dv_o |-> mii_rxd_o == 4'h0)
        else $error("receive data not zero while data valid low");
    a_rx_timing: assert property ($changed(mii_rx_dv_o) || $changed(mii_rxd_o) |-> $rose(mii_rx_clk_o))
        else $error("receive outputs moved away from receive clock rise");
    a_rxer_valid: assert property (mii_rx_er_o |-> mii_rx_dv_o)
        else $error("receive error outside a frame");
    a_col_carrier: assert property (mii_col_o |-> mii_crs_o || $past(mii_crs_o))
        else $error("collision without carrier");
    a_pair_onehot: assert property (up_r == 3'h7 |-> pair_a_is_tx_o != pair_b_is_tx_o)
        else $error("pair roles not exclusive");
    a_dpd_link: assert property (deep_power_down_o |-> !$past(line_rx_i.link, 5))
        else $error("deep power down while link up");
    a_dpd_wake: assert property ($rose(mii_tx_en_i) |-> ##[1:6] !deep_power_down_o)
        else $error("deep power down kept while transmitting");
    a_dpd_delay: assert property ($rose(deep_power_down_o) |-> quiet_r + 2 >= DPD_CYC && quiet_r <= DPD_CYC + 8)
        else $error("deep power down entry delay wrong");
endmodule // pmx_mii_port_monitor
`default_nettype wire

// *** dv/pmx_mii_port_tb.sv ***
// self-checking bench for the mii port block
`timescale 1ns/100ps
`default_nettype none
module pmx_mii_port_tb;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, mii_tx_clk_o, mii_tx_en_i, mii_rx_clk_o;
    logic mii_rx_dv_o, mii_rx_er_o, mii_crs_o, mii_col_o, mii_oe_o, crossover_auto_enable_i, line_tx_en_o;
    logic pair_a_is_tx_o, pair_b_is_tx_o, an_start_o, deep_power_down_o, lrun, dirty, txp, rxp, sa, sb;
    logic col_seen, er_seen;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i, mii_txd_i, mii_rxd_o, line_txd_o;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    logic [2:0] mgmt_addr_i;
    pmx_pkg::pmx_line_rx_t line_rx_i;
    logic [3:0] txq[$];
    int n_errors = 0, checks_done = 0, cyc = 0, nrx = 0;
    pmx_mii_port #(.DPD_CYC(100), .DWELL_CYC(20)) pmx_mii_port_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .mii_tx_clk_o, .mii_tx_en_i, .mii_txd_i,
        .mii_rx_clk_o, .mii_rx_dv_o, .mii_rxd_o, .mii_rx_er_o, .mii_crs_o, .mii_col_o, .mii_oe_o, .mgmt_addr_i,
        .crossover_auto_enable_i, .line_rx_i, .line_tx_en_o, .line_txd_o, .pair_a_is_tx_o, .pair_b_is_tx_o,
        .an_start_o, .deep_power_down_o);
    pmx_mac_model pmx_mac_model_inst (.clk_i, .rst_i, .tx_clk_i(mii_tx_clk_o), .dirty_idle_i(dirty),
        .tx_en_o(mii_tx_en_i), .txd_o(mii_txd_i));
    // ----------------------------------------
    // clocks and watchers
    // ----------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    // link clock, phase unrelated to the system clock
    initial begin
        #3;
        forever #16 if (lrun) line_rx_i.clk = ~line_rx_i.clk;
    end
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        txp <= mii_tx_clk_o;
        rxp <= mii_rx_clk_o;
        if (mii_tx_clk_o && !txp && line_tx_en_o === 1'b1) txq.push_back(line_txd_o);
        if (mii_rx_clk_o && !rxp && mii_rx_dv_o === 1'b1) begin
            nrx <= nrx + 1;
            if (mii_rx_er_o === 1'b1) er_seen <= 1'b1;
            cmp("rx nibble", 4'h5, mii_rxd_o);
        end
        if (mii_col_o === 1'b1) col_seen <= 1'b1;
        if (cyc == 20000) begin
            n_errors++;
            end_of_test();
        end
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task end_of_test;
        $display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= 4'hf;
        wb_adr_i <= a;
        wb_dat_i <= d;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) @(posedge clk_i);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task do_reset(input logic [2:0] addr);
        rst_i <= 1'b1;
        mgmt_addr_i <= addr;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask
    task period(input logic rx, input int e);
        int k;
        int m;
        k = 0;
        m = 0;
        while (k < 2 && m < 400) begin
            @(posedge clk_i);
            m++;
            if (rx ? (mii_rx_clk_o && !rxp) : (mii_tx_clk_o && !txp)) begin
                k++;
                if (k == 1) m = 0;
            end
        end
        cmp(rx ? "rx clock period" : "tx clock period", e, m);
    endtask
    task rx_frame(input int len, input logic by_tr);
        line_rx_i.nib <= 4'h5;
        line_rx_i.jk <= 1'b1;
        repeat (3) @(posedge clk_i);
        line_rx_i.jk <= 1'b0;
        repeat (len) @(posedge clk_i);
        cmp("carrier up", 1, mii_crs_o);
        line_rx_i.err <= 1'b1;
        repeat (3) @(posedge clk_i);
        line_rx_i.err <= 1'b0;
        repeat (len) @(posedge clk_i);
        line_rx_i.tr <= by_tr;
        line_rx_i.idle <= !by_tr;
        repeat (3) @(posedge clk_i);
        line_rx_i.tr <= 1'b0;
        line_rx_i.idle <= 1'b0;
        repeat (8) @(posedge clk_i);
        cmp("carrier down", 0, mii_crs_o);
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        line_rx_i = '0;
        lrun = 1'b0;
        dirty = 1'b0;
        col_seen = 1'b0;
        er_seen = 1'b0;
        crossover_auto_enable_i = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'hf;
        wb_dat_i = 32'h0;
        do_reset(3'h1);
        wb(1'b0, pmx_pkg::REG_CTRL, 32'h0);
        cmp("ctrl reset", pmx_pkg::CTRL_RST, q);
        wb(1'b0, pmx_pkg::REG_XOVER, 32'h0);
        cmp("xover reset", pmx_pkg::XOVER_RST, q);
        wb(1'b1, pmx_pkg::REG_STAT, 32'hffff_ffff);
        wb(1'b0, pmx_pkg::REG_STAT, 32'h0);
        cmp("status strap", 32'h100, q & 32'h760);
        wb(1'b1, 8'h80, 32'hffff_ffff);
        wb(1'b0, 8'h80, 32'h0);
        cmp("unmapped read", 0, q);
        cmp("outputs driven", 1, mii_oe_o);
        sa = 1'b0;
        sb = 1'b0;
        repeat (60) begin
            @(posedge clk_i);
            sa = sa | pair_a_is_tx_o;
            sb = sb | pair_b_is_tx_o;
        end
        cmp("hunt swaps", 3, {sa, sb});
        cmp("autoneg held", 0, an_start_o);
        for (int i = 0; i < 3; i++) begin
            crossover_auto_enable_i <= i != 2;
            wb(1'b1, pmx_pkg::REG_XOVER, i == 0 ? 32'h100 : (i == 1 ? 32'h0 : 32'h200));
            repeat (4) @(posedge clk_i);
            cmp("pair select", i == 0 ? 1 : 2, {pair_a_is_tx_o, pair_b_is_tx_o});
        end
        crossover_auto_enable_i <= 1'b1;
        wb(1'b1, pmx_pkg::REG_XOVER, 32'h200);
        period(1'b0, 10);
        period(1'b1, 10);
        line_rx_i.link <= 1'b1;
        lrun = 1'b1;
        repeat (10) @(posedge clk_i);
        cmp("autoneg start", 1, an_start_o);
        period(1'b1, 8);
        dirty <= 1'b1;
        for (int i = 1; i <= 8; i++) pmx_mac_model_inst.send(4'(i));
        rx_frame(100, 1'b1);
        cmp("rx nibble count", 1, nrx >= 23 && nrx <= 28);
        cmp("rx error seen", 1, er_seen);
        cmp("collision seen", 1, col_seen);
        cmp("tx nibble count", 8, txq.size());
        foreach (txq[i]) cmp("tx nibble", i + 1, txq[i]);
        wb(1'b1, pmx_pkg::REG_CTRL, 32'h7);
        col_seen = 1'b0;
        for (int i = 1; i <= 4; i++) pmx_mac_model_inst.send(4'(i));
        rx_frame(60, 1'b0);
        cmp("full duplex collision", 0, col_seen);
        wb(1'b1, pmx_pkg::REG_CTRL, 32'h4);
        lrun = 1'b0;
        period(1'b0, 100);
        period(1'b1, 100);
        lrun = 1'b1;
        line_rx_i.pre <= 1'b1;
        repeat (3) @(posedge clk_i);
        line_rx_i.pre <= 1'b0;
        repeat (20) @(posedge clk_i);
        cmp("10M carrier up", 1, mii_crs_o);
        cmp("10M valid on preamble", 0, mii_rx_dv_o);
        line_rx_i.sfd <= 1'b1;
        repeat (3) @(posedge clk_i);
        line_rx_i.sfd <= 1'b0;
        repeat (20) @(posedge clk_i);
        cmp("10M valid on sfd", 1, mii_rx_dv_o);
        period(1'b1, 8);
        line_rx_i.eof <= 1'b1;
        repeat (3) @(posedge clk_i);
        line_rx_i.eof <= 1'b0;
        repeat (120) @(posedge clk_i);
        cmp("10M carrier and valid down", 0, {mii_crs_o, mii_rx_dv_o});
        lrun = 1'b0;
        line_rx_i.link <= 1'b0;
        dirty <= 1'b0;
        repeat (130) @(posedge clk_i);
        cmp("deep power down", 1, deep_power_down_o);
        pmx_mac_model_inst.send(4'h3);
        wait (mii_tx_en_i === 1'b1);
        repeat (8) @(posedge clk_i);
        cmp("power down left", 0, deep_power_down_o);
        do_reset(3'h0);
        cmp("outputs isolated", 0, mii_oe_o);
        wb(1'b0, pmx_pkg::REG_STAT, 32'h0);
        cmp("status isolated", 32'h40, q & 32'h740);
        do_reset(3'h1);
        cmp("outputs driven", 1, mii_oe_o);
        end_of_test();
    end
endmodule // pmx_mii_port_tb
bind pmx_mii_port pmx_mii_port_monitor #(.DPD_CYC(DPD_CYC)) pmx_mii_port_monitor_inst (.clk_i, .rst_i,
    .wb_cyc_i, .wb_stb_i, .wb_ack_o, .mii_tx_clk_o, .mii_tx_en_i, .mii_rx_clk_o, .mii_rx_dv_o, .mii_rxd_o,
    .mii_rx_er_o, .mii_crs_o, .mii_col_o, .line_rx_i, .line_tx_en_o, .line_txd_o, .pair_a_is_tx_o,
    .pair_b_is_tx_o, .deep_power_down_o);
`default_nettype wire

// *** inc/pmx_pkg.sv ***
// shared constants and types for the mii port and pair select block
package pmx_pkg;
    // timing
    localparam longint CLK_HZ = 64'd250_000_000;
    localparam longint REF_HZ = 64'd25_000_000;
    localparam int REF_DIV = int'(CLK_HZ / REF_HZ);
    localparam int SLOW_DIV = 10;
    localparam int HALF_CNT = 5;
    localparam longint DPD_TIME_S = 64'd32;
    localparam longint DPD_CYCLES = DPD_TIME_S * CLK_HZ;
    localparam longint PAIR_DWELL_US = 64'd200;
    localparam longint PAIR_DWELL_CYC = PAIR_DWELL_US * CLK_HZ / 64'd1_000_000;
    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_XOVER_IDX = 8'h13;
    localparam logic [7:0] REG_XOVER = REG_XOVER_IDX << 2;
    // control fields
    localparam int CTRL_SPEED100 = 0;
    localparam int CTRL_FULLDPX = 1;
    localparam int CTRL_AN_EN = 2;
    localparam logic [31:0] CTRL_RST = 32'h0000_0005;
    // crossover fields
    localparam int XO_AUTO_EN = 9;
    localparam int XO_FORCED = 8;
    localparam logic [31:0] XOVER_RST = 32'h0000_0200;
    // status fields
    localparam int ST_LINK = 0;
    localparam int ST_CRS = 1;
    localparam int ST_COL = 2;
    localparam int ST_DPD = 3;
    localparam int ST_CROSS = 4;
    localparam int ST_PAIR_DONE = 5;
    localparam int ST_ISOLATE = 6;
    localparam int ST_ADDR = 8;
    // line-side receive indications from the analog/decoder front end
    typedef struct packed {
        logic clk;
        logic link;
        logic sig_det;
        logic pre;
        logic sfd;
        logic eof;
        logic jk;
        logic tr;
        logic idle;
        logic err;
        logic [3:0] nib;
    } pmx_line_rx_t;
    // pair selection states
    typedef enum logic [2:0] {
        PS_MANUAL = 3'b001,
        PS_HUNT = 3'b010,
        PS_LOCK = 3'b100
    } pmx_pair_st_t;
endpackage

// *** verilog/pmx_mii_port.sv ***
// mii port, carrier/collision, pair selection and deep power-down of the phy
//
// The address map and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module pmx_mii_port #(
    parameter longint DPD_CYC = pmx_pkg::DPD_CYCLES,
    parameter longint DWELL_CYC = pmx_pkg::PAIR_DWELL_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // mac side
    output logic mii_tx_clk_o,
    input wire logic mii_tx_en_i,
    input wire logic [3:0] mii_txd_i,
    output logic mii_rx_clk_o,
    output logic mii_rx_dv_o,
    output logic [3:0] mii_rxd_o,
    output logic mii_rx_er_o,
    output logic mii_crs_o,
    output logic mii_col_o,
    output logic mii_oe_o,
    // straps and pins
    input wire logic [2:0] mgmt_addr_i,
    input wire logic crossover_auto_enable_i,
    // line side
    input wire pmx_pkg::pmx_line_rx_t line_rx_i,
    output logic line_tx_en_o,
    output logic [3:0] line_txd_o,
    output logic pair_a_is_tx_o,
    output logic pair_b_is_tx_o,
    output logic an_start_o,
    output logic deep_power_down_o
);

    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic wrap(input logic [3:0] cnt);
        return cnt == 4'(pmx_pkg::SLOW_DIV - 1);
    endfunction

    // -----------------------------------------------------------------
    // input synchronisers
    // -----------------------------------------------------------------
    pmx_pkg::pmx_line_rx_t ln_s1_r;
    pmx_pkg::pmx_line_rx_t ln_r;
    logic [4:0] mac_s1_r;
    logic [4:0] mac_s2_r;
    logic [3:0] pin_s1_r;
    logic [3:0] pin_s2_r;

    always_ff @(posedge clk_i) begin
        ln_s1_r <= line_rx_i;
        ln_r <= ln_s1_r;
        mac_s1_r <= {mii_tx_en_i, mii_txd_i};
        mac_s2_r <= mac_s1_r;
        pin_s1_r <= {crossover_auto_enable_i, mgmt_addr_i};
        pin_s2_r <= pin_s1_r;
    end

    wire tx_en_s = mac_s2_r[4];
    wire [3:0] txd_s = mac_s2_r[3:0];
    wire auto_pin_s = pin_s2_r[3];

    // -----------------------------------------------------------------
    // registers
    // -----------------------------------------------------------------
    logic [31:0] ctrl_r;
    logic [31:0] xover_r;
    logic ack_r;
    logic [31:0] rd_r;
    logic [2:0] addr_r;
    logic strap_done_r;

    wire speed100 = ctrl_r[pmx_pkg::CTRL_SPEED100];
    wire half_dpx = ~ctrl_r[pmx_pkg::CTRL_FULLDPX];
    wire an_en = ctrl_r[pmx_pkg::CTRL_AN_EN];
    wire req = wb_cyc_i & wb_stb_i & ~ack_r;
    wire wr = req & wb_we_i;
    wire hit_ctrl = wb_adr_i == pmx_pkg::REG_CTRL;
    wire hit_stat = wb_adr_i == pmx_pkg::REG_STAT;
    wire hit_xo = wb_adr_i == pmx_pkg::REG_XOVER;

    logic [31:0] stat_w;
    logic [31:0] rd_w;
    logic crs_r;
    logic dpd_r;
    logic cross_r;
    logic pair_done;

    always_comb begin
        stat_w = 32'h0;
        stat_w[pmx_pkg::ST_LINK] = ln_r.link;
        stat_w[pmx_pkg::ST_CRS] = crs_r;
        stat_w[pmx_pkg::ST_COL] = mii_col_o;
        stat_w[pmx_pkg::ST_DPD] = dpd_r;
        stat_w[pmx_pkg::ST_CROSS] = cross_r;
        stat_w[pmx_pkg::ST_PAIR_DONE] = pair_done;
        stat_w[pmx_pkg::ST_ISOLATE] = ~mii_oe_o;
        stat_w[pmx_pkg::ST_ADDR +: 3] = addr_r;
    end

    assign rd_w = hit_ctrl ? ctrl_r :
                  hit_stat ? stat_w :
                  hit_xo ? xover_r : 32'h0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= pmx_pkg::CTRL_RST;
            xover_r <= pmx_pkg::XOVER_RST;
            ack_r <= 1'b0;
            rd_r <= 32'h0;
        end else begin
            ack_r <= req;
            if (req) begin
                rd_r <= rd_w;
            end
            if (wr && hit_ctrl) begin
                ctrl_r <= merge(ctrl_r, wb_dat_i, wb_sel_i);
            end
            if (wr && hit_xo) begin
                xover_r <= merge(xover_r, wb_dat_i, wb_sel_i);
            end
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rd_r;

    // strap caught on the first edge after reset release
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            strap_done_r <= 1'b0;
        end else begin
            strap_done_r <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!strap_done_r) begin
            addr_r <= pin_s2_r[2:0];
        end
    end

    assign mii_oe_o = strap_done_r & (addr_r != 3'h0);

    // -----------------------------------------------------------------
    // local clocks: 25 MHz reference, divided by ten for 10 Mb/s
    // -----------------------------------------------------------------
    logic [3:0] ref_cnt_r;
    logic [3:0] slow_cnt_r;
    logic loc_clk_r;
    logic loc_clk_d_r;

    wire ref_tick = ref_cnt_r == 4'(pmx_pkg::REF_DIV - 1);
    wire ref_half = ref_tick | (ref_cnt_r == 4'(pmx_pkg::HALF_CNT - 1));
    wire slow_half = ref_tick & (wrap(slow_cnt_r) |
                     (slow_cnt_r == 4'(pmx_pkg::HALF_CNT - 1)));
    wire loc_tgl = speed100 ? ref_half : slow_half;
    wire loc_fall = ~loc_clk_r & loc_clk_d_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ref_cnt_r <= 4'h0;
            slow_cnt_r <= 4'h0;
            loc_clk_r <= 1'b0;
            loc_clk_d_r <= 1'b0;
        end else begin
            ref_cnt_r <= ref_tick ? 4'h0 : ref_cnt_r + 4'h1;
            if (ref_tick) begin
                slow_cnt_r <= wrap(slow_cnt_r) ? 4'h0 : slow_cnt_r + 4'h1;
            end
            if (loc_tgl) begin
                loc_clk_r <= ~loc_clk_r;
            end
            loc_clk_d_r <= loc_clk_r;
        end
    end

    assign mii_tx_clk_o = loc_clk_r;

    // -----------------------------------------------------------------
    // transmit path: sample mid-period, away from the mac's launch edge
    // -----------------------------------------------------------------
    logic tx_en_r;
    logic [3:0] txd_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_en_r <= 1'b0;
            txd_r <= 4'h0;
        end else if (loc_fall) begin
            tx_en_r <= tx_en_s;
            txd_r <= tx_en_s ? txd_s : 4'h0;
        end
    end

    assign line_tx_en_o = tx_en_r;
    assign line_txd_o = txd_r;

    // -----------------------------------------------------------------
    // carrier sense and collision
    // -----------------------------------------------------------------
    logic dv10_r;

    wire crs_set = speed100 ? ln_r.jk : ln_r.pre;
    wire crs_clr = speed100 ? (ln_r.tr | ln_r.idle) : ln_r.eof;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            crs_r <= 1'b0;
            dv10_r <= 1'b0;
        end else begin
            if (crs_clr) begin
                crs_r <= 1'b0;
            end else if (crs_set) begin
                crs_r <= 1'b1;
            end
            if (ln_r.eof || !crs_r) begin
                dv10_r <= 1'b0;
            end else if (ln_r.sfd) begin
                dv10_r <= 1'b1;
            end
        end
    end

    assign mii_crs_o = crs_r;
    // free of both mii clocks
    assign mii_col_o = half_dpx & tx_en_s & crs_r;

    // -----------------------------------------------------------------
    // receive clock source and receive outputs
    // -----------------------------------------------------------------
    logic rx_clk_r;
    logic rx_dv_r;
    logic [3:0] rxd_r;
    logic rx_er_r;
    logic err_seen_r;

    wire rx_from_line = speed100 ? ln_r.link : (ln_r.link & crs_r);
    wire rx_clk_w = rx_from_line ? ln_r.clk : loc_clk_r;
    // rise of the emitted clock itself, so a source switch never moves data off an edge
    wire rx_rise = rx_clk_w & ~rx_clk_r;
    wire dv_w = speed100 ? crs_r : dv10_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_clk_r <= 1'b0;
            rx_dv_r <= 1'b0;
            rxd_r <= 4'h0;
            rx_er_r <= 1'b0;
            err_seen_r <= 1'b0;
        end else begin
            rx_clk_r <= rx_clk_w;
            if (rx_rise) begin
                rx_dv_r <= dv_w;
                rxd_r <= dv_w ? ln_r.nib : 4'h0;
                rx_er_r <= dv_w & (err_seen_r | ln_r.err);
            end
            if (ln_r.err && dv_w) begin
                err_seen_r <= 1'b1;
            end else if (rx_rise) begin
                err_seen_r <= 1'b0;
            end
        end
    end

    assign mii_rx_clk_o = rx_clk_r;
    assign mii_rx_dv_o = rx_dv_r;
    assign mii_rxd_o = rxd_r;
    assign mii_rx_er_o = rx_er_r;

    // -----------------------------------------------------------------
    // pair selection
    // -----------------------------------------------------------------
    pmx_pkg::pmx_pair_st_t ps_r;
    pmx_pkg::pmx_pair_st_t ps_nxt;
    logic [63:0] dwell_r;
    logic cross_nxt;

    wire xo_auto = xover_r[pmx_pkg::XO_AUTO_EN];
    wire xo_forced = xover_r[pmx_pkg::XO_FORCED];
    wire auto_on = xo_auto & auto_pin_s;
    wire man_cross = ~xo_auto & xo_forced;
    wire dwell_end = dwell_r == 64'(DWELL_CYC - 1);
    wire line_ok = ln_r.link | ln_r.sig_det;

    always_comb begin
        ps_nxt = ps_r;
        cross_nxt = cross_r;
        case (ps_r)
            pmx_pkg::PS_MANUAL: begin
                cross_nxt = man_cross;
                if (auto_on) begin
                    ps_nxt = pmx_pkg::PS_HUNT;
                end
            end
            pmx_pkg::PS_HUNT: begin
                if (!auto_on) begin
                    ps_nxt = pmx_pkg::PS_MANUAL;
                end else if (line_ok) begin
                    ps_nxt = pmx_pkg::PS_LOCK;
                end else if (dwell_end) begin
                    cross_nxt = ~cross_r;
                end
            end
            pmx_pkg::PS_LOCK: begin
                if (!auto_on) begin
                    ps_nxt = pmx_pkg::PS_MANUAL;
                end else if (!line_ok) begin
                    ps_nxt = pmx_pkg::PS_HUNT;
                end
            end
            default: begin
                ps_nxt = pmx_pkg::PS_MANUAL;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ps_r <= pmx_pkg::PS_MANUAL;
            cross_r <= 1'b0;
            dwell_r <= 64'h0;
        end else begin
            ps_r <= ps_nxt;
            cross_r <= cross_nxt;
            if (ps_r != pmx_pkg::PS_HUNT || dwell_end || line_ok) begin
                dwell_r <= 64'h0;
            end else begin
                dwell_r <= dwell_r + 64'h1;
            end
        end
    end

    assign pair_done = ps_r != pmx_pkg::PS_HUNT;
    assign pair_a_is_tx_o = ~cross_r;
    assign pair_b_is_tx_o = cross_r;
    assign an_start_o = an_en & pair_done;

    // -----------------------------------------------------------------
    // deep power-down
    // -----------------------------------------------------------------
    logic [63:0] dpd_cnt_r;

    wire dpd_cond = ~ln_r.link & ~tx_en_s;
    wire dpd_hit = dpd_cnt_r == 64'(DPD_CYC - 1);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dpd_cnt_r <= 64'h0;
            dpd_r <= 1'b0;
        end else if (!dpd_cond) begin
            dpd_cnt_r <= 64'h0;
            dpd_r <= 1'b0;
        end else if (!dpd_r) begin
            if (dpd_hit) begin
                dpd_r <= 1'b1;
            end else begin
                dpd_cnt_r <= dpd_cnt_r + 64'h1;
            end
        end
    end

    assign deep_power_down_o = dpd_r;

endmodule // pmx_mii_port

`default_nettype wire
